// file: logic/amsp_serial_unit.sv
// serial_unit: async transmit/receive with multiprocessor format, apb regs
// assumes rxd is asynchronous; baud divisor plus one gives pclk cycles per bit
// Function
// R1: marker bit 1 for id, 0 data
// R2: sender sends id marked, then data unmarked
// R3: marked frame compared to id, mismatch skips
// R4: multiprocessor format ignores parity setting
// R5: start, eight data lsb first, marker, stop
// R6: empty flag 0 loads shifter, sets flag
// R7: stop bit samples flag, chains next frame
// R8: flag 1 at stop sets end, idles mark
// R9: six causes share one interrupt output
// R10: tx empty and end irqs follow flags
// R11: tx empty and end flags reset to 1
// R12: rx full and error irqs gated by rie
// R13: holding write clears empty flag
// R14: holding writes always accepted, may overwrite
// R15: software writes holding once after empty
// R16: overrun sets flag, keeps data register
// R17: simultaneous errors set all, transfer unless overrun
// R18: skipped frames update nothing
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module amsp_serial_unit #(
    parameter int BAUD_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic irq,
    output logic tx_empty_irq,
    output logic tx_end_irq,
    output logic rx_full_irq,
    output logic rx_error_irq
);
    localparam int CW = amsp_pkg::CTRL_W;
    localparam int SW = amsp_pkg::ST_W;
    localparam int IW = amsp_pkg::IRQ_W;

    function automatic logic par_of(input logic [7:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction

    // bus and registers
    logic [CW-1:0] ctrl_reg, ctrl_next;
    logic [BAUD_W-1:0] baud_reg, baud_next;
    logic [7:0] id_reg, id_next;
    logic [7:0] tx_hold_reg, tx_hold_next;
    logic [7:0] rx_data_reg, rx_data_next;
    logic [SW-1:0] status_reg, status_next;
    logic [IW-1:0] ist_reg, ist_next, ien_reg, ien_next;
    logic [IW-1:0] lvl_reg, lvl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    // tx state
    amsp_pkg::amsp_phase_t tph_reg, tph_next;
    logic [BAUD_W-1:0] tcnt_reg, tcnt_next;
    logic [3:0] tbit_reg, tbit_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic tx_mp_reg, tx_mp_next, txd_reg, txd_next;
    // rx state
    amsp_pkg::amsp_phase_t rph_reg, rph_next;
    logic [BAUD_W-1:0] rcnt_reg, rcnt_next;
    logic [3:0] rbit_reg, rbit_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic rx_ext_reg, rx_ext_next;
    logic rs1_reg, rs2_reg;

    wire logic acc = psel & penable & pready_reg;
    wire logic wr = acc & pwrite;
    wire logic rd = acc & ~pwrite;
    wire logic mp = ctrl_reg[amsp_pkg::CTRL_MP];
    wire logic par_on = ctrl_reg[amsp_pkg::CTRL_PAR_EN] & ~mp; // R4
    wire logic tick_t = (tcnt_reg == '0);
    wire logic tick_r = (rcnt_reg == '0);
    wire logic [BAUD_W-1:0] half = baud_reg >> 1;

    always_comb begin
        ctrl_next = ctrl_reg;
        baud_next = baud_reg;
        id_next = id_reg;
        tx_hold_next = tx_hold_reg;
        rx_data_next = rx_data_reg;
        status_next = status_reg;
        ien_next = ien_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = psel & ~penable;
        tph_next = tph_reg;
        tcnt_next = tick_t ? baud_reg : tcnt_reg - 1'b1;
        tbit_next = tbit_reg;
        tx_shift_next = tx_shift_reg;
        tx_mp_next = tx_mp_reg;
        txd_next = txd_reg;
        rph_next = rph_reg;
        rcnt_next = rcnt_reg - 1'b1;
        rbit_next = rbit_reg;
        rx_shift_next = rx_shift_reg;
        rx_ext_next = rx_ext_reg;
        // software side, hardware sets below win afterwards
        if (psel & ~penable & ~pwrite) begin
            case (paddr)
                amsp_pkg::ADDR_CTRL: prdata_next = 32'(ctrl_reg);
                amsp_pkg::ADDR_STAT: prdata_next = 32'(status_reg);
                amsp_pkg::ADDR_TXH: prdata_next = 32'(tx_hold_reg);
                amsp_pkg::ADDR_RXD: prdata_next = 32'(rx_data_reg);
                amsp_pkg::ADDR_BAUD: prdata_next = 32'(baud_reg);
                amsp_pkg::ADDR_ID: prdata_next = 32'(id_reg);
                amsp_pkg::ADDR_IRQ_ST: prdata_next = 32'(ist_reg);
                amsp_pkg::ADDR_IRQ_EN: prdata_next = 32'(ien_reg);
                amsp_pkg::ADDR_IRQ_CLR: prdata_next = 32'h0;
                default: prdata_next = 32'h0;
            endcase
            if (paddr > amsp_pkg::ADDR_IRQ_CLR || paddr[1:0] != 2'b00) begin
                pslverr_next = 1'b1;
            end
        end else if (psel & ~penable & pwrite) begin
            pslverr_next = (paddr > amsp_pkg::ADDR_IRQ_CLR) ||
                           (paddr[1:0] != 2'b00);
        end
        if (wr) begin
            case (paddr)
                amsp_pkg::ADDR_CTRL: ctrl_next = pwdata[CW-1:0];
                amsp_pkg::ADDR_BAUD: baud_next = pwdata[BAUD_W-1:0];
                amsp_pkg::ADDR_ID: id_next = pwdata[7:0];
                amsp_pkg::ADDR_IRQ_EN: ien_next = pwdata[IW-1:0];
                amsp_pkg::ADDR_TXH: begin
                    tx_hold_next = pwdata[7:0]; // R14
                    status_next[amsp_pkg::ST_TX_EMPTY] = 1'b0; // R13
                    status_next[amsp_pkg::ST_TX_END] = 1'b0;
                end
                amsp_pkg::ADDR_STAT: begin
                    // error flags cleared by writing 0
                    status_next[amsp_pkg::ST_OVERRUN] =
                        status_reg[amsp_pkg::ST_OVERRUN] &
                        pwdata[amsp_pkg::ST_OVERRUN];
                    status_next[amsp_pkg::ST_FRAMING] =
                        status_reg[amsp_pkg::ST_FRAMING] &
                        pwdata[amsp_pkg::ST_FRAMING];
                    status_next[amsp_pkg::ST_PARITY] =
                        status_reg[amsp_pkg::ST_PARITY] &
                        pwdata[amsp_pkg::ST_PARITY];
                end
                default: ;
            endcase
        end
        if (rd && paddr == amsp_pkg::ADDR_RXD) begin
            status_next[amsp_pkg::ST_RX_FULL] = 1'b0;
        end
        // transmitter
        if (!ctrl_reg[amsp_pkg::CTRL_TX_EN]) begin
            tph_next = amsp_pkg::AMSP_IDLE;
            txd_next = 1'b1;
            status_next[amsp_pkg::ST_TX_EMPTY] = 1'b1;
        end else begin
            case (tph_reg)
                amsp_pkg::AMSP_IDLE: begin
                    txd_next = 1'b1; // R8
                    if (!status_reg[amsp_pkg::ST_TX_EMPTY] && !wr) begin
                        tx_shift_next = tx_hold_reg; // R6
                        tx_mp_next = ctrl_reg[amsp_pkg::CTRL_MP_TX_BIT]; // R1
                        status_next[amsp_pkg::ST_TX_EMPTY] = 1'b1; // R6
                        tph_next = amsp_pkg::AMSP_START;
                        tcnt_next = baud_reg;
                        txd_next = 1'b0;
                    end
                end
                amsp_pkg::AMSP_START: if (tick_t) begin
                    tph_next = amsp_pkg::AMSP_DATA;
                    tbit_next = 4'h0;
                    txd_next = tx_shift_reg[0]; // R5
                end
                amsp_pkg::AMSP_DATA: if (tick_t) begin
                    if (tbit_reg == 4'(amsp_pkg::DATA_BITS - 1)) begin
                        if (mp) begin
                            tph_next = amsp_pkg::AMSP_EXTRA;
                            txd_next = tx_mp_reg; // R1
                        end else if (par_on) begin
                            tph_next = amsp_pkg::AMSP_EXTRA;
                            txd_next = par_of(tx_shift_reg,
                                ctrl_reg[amsp_pkg::CTRL_PAR_ODD]);
                        end else begin
                            tph_next = amsp_pkg::AMSP_STOP;
                            txd_next = 1'b1;
                        end
                    end else begin
                        tbit_next = tbit_reg + 4'h1;
                        txd_next = tx_shift_reg[tbit_reg[2:0] + 3'h1]; // R5
                    end
                end
                amsp_pkg::AMSP_EXTRA: if (tick_t) begin
                    tph_next = amsp_pkg::AMSP_STOP;
                    txd_next = 1'b1;
                end
                amsp_pkg::AMSP_STOP: if (tick_t) begin
                    if (!status_next[amsp_pkg::ST_TX_EMPTY]) begin
                        tx_shift_next = tx_hold_next; // R7
                        tx_mp_next = ctrl_reg[amsp_pkg::CTRL_MP_TX_BIT];
                        status_next[amsp_pkg::ST_TX_EMPTY] = 1'b1;
                        tph_next = amsp_pkg::AMSP_START;
                        txd_next = 1'b0;
                    end else begin
                        status_next[amsp_pkg::ST_TX_END] = 1'b1; // R8
                        tph_next = amsp_pkg::AMSP_IDLE;
                        txd_next = 1'b1;
                    end
                end
                default: tph_next = amsp_pkg::AMSP_IDLE;
            endcase
        end
        // receiver
        if (!ctrl_reg[amsp_pkg::CTRL_RX_EN]) begin
            rph_next = amsp_pkg::AMSP_IDLE;
        end else begin
            case (rph_reg)
                amsp_pkg::AMSP_IDLE: if (!rs2_reg) begin
                    rph_next = amsp_pkg::AMSP_START;
                    rcnt_next = half;
                end
                amsp_pkg::AMSP_START: if (tick_r) begin
                    rph_next = rs2_reg ? amsp_pkg::AMSP_IDLE
                                       : amsp_pkg::AMSP_DATA;
                    rbit_next = 4'h0;
                    rcnt_next = baud_reg;
                end
                amsp_pkg::AMSP_DATA: if (tick_r) begin
                    rx_shift_next = {rs2_reg, rx_shift_reg[7:1]}; // R5
                    rcnt_next = baud_reg;
                    rbit_next = rbit_reg + 4'h1;
                    if (rbit_reg == 4'(amsp_pkg::DATA_BITS - 1)) begin
                        rph_next = (mp | par_on) ? amsp_pkg::AMSP_EXTRA
                                                 : amsp_pkg::AMSP_STOP;
                    end
                end
                amsp_pkg::AMSP_EXTRA: if (tick_r) begin
                    rx_ext_next = rs2_reg;
                    rcnt_next = baud_reg;
                    rph_next = amsp_pkg::AMSP_STOP;
                end
                amsp_pkg::AMSP_STOP: if (tick_r) begin
                    rph_next = amsp_pkg::AMSP_IDLE;
                    if (mp && rx_ext_reg) begin
                        // R3
                        status_next[amsp_pkg::ST_SKIP] =
                            (rx_shift_reg != id_reg);
                        status_next[amsp_pkg::ST_MP_RX] = 1'b1;
                    end
                    if (!(mp && !rx_ext_reg && status_reg[amsp_pkg::ST_SKIP]))
                    begin // R18
                        if (mp) begin
                            status_next[amsp_pkg::ST_MP_RX] = rx_ext_reg;
                        end
                        if (!rs2_reg) begin
                            status_next[amsp_pkg::ST_FRAMING] = 1'b1; // R17
                        end
                        if (par_on && rx_ext_reg != par_of(rx_shift_reg,
                            ctrl_reg[amsp_pkg::CTRL_PAR_ODD])) begin
                            status_next[amsp_pkg::ST_PARITY] = 1'b1; // R17
                        end
                        if (status_reg[amsp_pkg::ST_RX_FULL]) begin
                            status_next[amsp_pkg::ST_OVERRUN] = 1'b1; // R16
                            status_next[amsp_pkg::ST_RX_FULL] = 1'b1; // R16
                        end else begin
                            rx_data_next = rx_shift_reg; // R17
                            status_next[amsp_pkg::ST_RX_FULL] = 1'b1;
                        end
                    end
                end
                default: rph_next = amsp_pkg::AMSP_IDLE;
            endcase
        end
        // interrupt levels from flags and enables
        lvl_next[amsp_pkg::IRQ_TXE] = status_next[amsp_pkg::ST_TX_EMPTY] &
            ctrl_next[amsp_pkg::CTRL_TIE]; // R10
        lvl_next[amsp_pkg::IRQ_TX_END_FLAG] = status_next[amsp_pkg::ST_TX_END] &
            ctrl_next[amsp_pkg::CTRL_TX_END_IRQ_EN]; // R10
        lvl_next[amsp_pkg::IRQ_RXF] = status_next[amsp_pkg::ST_RX_FULL] &
            ctrl_next[amsp_pkg::CTRL_RIE]; // R12
        lvl_next[amsp_pkg::IRQ_ERR] = (status_next[amsp_pkg::ST_OVERRUN] |
            status_next[amsp_pkg::ST_FRAMING] |
            status_next[amsp_pkg::ST_PARITY]) &
            ctrl_next[amsp_pkg::CTRL_RIE]; // R12
        // sticky status, set wins over clear
        ist_next = ist_reg;
        if (wr && paddr == amsp_pkg::ADDR_IRQ_CLR) begin
            ist_next = ist_reg & ~pwdata[IW-1:0];
        end
        ist_next = ist_next | (lvl_next & ~lvl_reg);
        irq_next = |(ist_next & ien_next); // R9
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= amsp_pkg::CTRL_RST;
            baud_reg <= BAUD_W'(amsp_pkg::BAUD_RST);
            id_reg <= amsp_pkg::ID_RST;
            tx_hold_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            // R11
            status_reg <= SW'((1 << amsp_pkg::ST_TX_EMPTY) |
                              (1 << amsp_pkg::ST_TX_END));
            ist_reg <= '0;
            ien_reg <= '0;
            lvl_reg <= '0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            tph_reg <= amsp_pkg::AMSP_IDLE;
            tcnt_reg <= '0;
            tbit_reg <= 4'h0;
            tx_shift_reg <= 8'h00;
            tx_mp_reg <= 1'b0;
            txd_reg <= 1'b1;
            rph_reg <= amsp_pkg::AMSP_IDLE;
            rcnt_reg <= '0;
            rbit_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_ext_reg <= 1'b0;
            rs1_reg <= 1'b1;
            rs2_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            baud_reg <= baud_next;
            id_reg <= id_next;
            tx_hold_reg <= tx_hold_next;
            rx_data_reg <= rx_data_next;
            status_reg <= status_next;
            ist_reg <= ist_next;
            ien_reg <= ien_next;
            lvl_reg <= lvl_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            tph_reg <= tph_next;
            tcnt_reg <= tcnt_next;
            tbit_reg <= tbit_next;
            tx_shift_reg <= tx_shift_next;
            tx_mp_reg <= tx_mp_next;
            txd_reg <= txd_next;
            rph_reg <= rph_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            rx_shift_reg <= rx_shift_next;
            rx_ext_reg <= rx_ext_next;
            rs1_reg <= rxd;
            rs2_reg <= rs1_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign txd = txd_reg;
    assign irq = irq_reg;
    assign tx_empty_irq = lvl_reg[amsp_pkg::IRQ_TXE];
    assign tx_end_irq = lvl_reg[amsp_pkg::IRQ_TX_END_FLAG];
    assign rx_full_irq = lvl_reg[amsp_pkg::IRQ_RXF];
    assign rx_error_irq = lvl_reg[amsp_pkg::IRQ_ERR];
endmodule // amsp_serial_unit

// file: logic/amsp_pkg.sv
// package for the async multiprocessor serial unit
// assumes a 20 MHz pclk and an apb master with 32-bit data
package amsp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TXH = 8'h08;
    localparam logic [7:0] ADDR_RXD = 8'h0c;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    localparam logic [7:0] ADDR_ID = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
    // control field positions
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_MP = 2;
    localparam int CTRL_PAR_EN = 3;
    localparam int CTRL_PAR_ODD = 4;
    localparam int CTRL_TIE = 5;
    localparam int CTRL_RIE = 6;
    localparam int CTRL_TX_END_IRQ_EN = 7;
    localparam int CTRL_MP_TX_BIT = 8;
    localparam int CTRL_W = 9;
    // status field positions
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_END = 1;
    localparam int ST_RX_FULL = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_FRAMING = 4;
    localparam int ST_PARITY = 5;
    localparam int ST_MP_RX = 6;
    localparam int ST_SKIP = 7;
    localparam int ST_W = 8;
    // interrupt line positions
    localparam int IRQ_TXE = 0;
    localparam int IRQ_TX_END_FLAG = 1;
    localparam int IRQ_RXF = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [15:0] BAUD_RST = 16'h0081;
    localparam logic [7:0] ID_RST = 8'h00;
    localparam int DATA_BITS = 8;
    typedef enum logic [2:0] {
        AMSP_IDLE, AMSP_START, AMSP_DATA, AMSP_EXTRA, AMSP_STOP
    } amsp_phase_t;
endpackage

// file: test/amsp_station.sv
// model of the other processor on the serial line
// drives the unit's rxd, decodes frames seen on txd; BIT = pclk per bit
`timescale 1ns/1ns
module amsp_station #(
    parameter int BIT = 4
) (
    input wire logic pclk,
    output logic rxd,
    input wire logic txd
);
    logic [9:0] got [$];
    logic [9:0] f;
    logic [10:0] fr;
    initial rxd = 1'b1;
    // start, data lsb first, marker, stop; stp 0 breaks framing
    task send(input logic [7:0] d, input logic mk, input logic stp);
        fr = {stp, mk, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rxd <= fr[i];
            repeat (BIT - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'b1;
    endtask
    // mid-bit capture of data, marker and stop
    initial begin
        forever begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge pclk);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT) @(posedge pclk);
                f[i] = txd;
            end
            got.push_back(f);
        end
    end
endmodule // amsp_station

// file: test/amsp_serial_unit_sva.sv
// checker for apb answers and interrupt outputs of the serial unit
// bound to amsp_serial_unit, sees only its ports
`timescale 1ns/1ns
module amsp_serial_unit_sva (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic rxd,
    input logic txd,
    input logic irq,
    input logic tx_empty_irq,
    input logic tx_end_irq,
    input logic rx_full_irq,
    input logic rx_error_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_next_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    pready_once_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    bad_addr_a: assert property (pready |->
        pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address");
    err_data_a: assert property (pready && pslverr && !pwrite |->
        prdata == 32'h0) else $error("refused read not zero");
    clr_read_a: assert property (pready && !pwrite &&
        paddr == amsp_pkg::ADDR_IRQ_CLR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    txe_clear_a: assert property ($fell(tx_empty_irq) |->
        $past(psel) || $past(psel, 2)) else $error("txe irq fell alone");
    rxf_clear_a: assert property ($fell(rx_full_irq) |->
        $past(psel) || $past(psel, 2)) else $error("rxf irq fell alone");
    err_clear_a: assert property ($fell(rx_error_irq) |->
        $past(psel) || $past(psel, 2)) else $error("err irq fell alone");
    tx_end_flag_mark_a: assert property ($rose(tx_end_irq) |-> txd)
        else $error("tx end raised while line low");
    start_end_a: assert property ($fell(txd) |-> ##[0:2] !tx_end_irq)
        else $error("tx end still set during frame");
    cover property ($fell(txd));
    cover property ($rose(rx_error_irq));
    cover property (pready && pslverr);
endmodule // amsp_serial_unit_sva
bind amsp_serial_unit amsp_serial_unit_sva amsp_serial_unit_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq),
    .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
    .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));

// file: test/amsp_serial_unit_bench.sv
// testbench for the async multiprocessor serial unit
// amsp_station plays the other processor, bit time 4 pclk
`timescale 1ns/1ns
module amsp_serial_unit_bench;
    logic pclk, presetn, psel, penable, pwrite, rxd, txd, irq, qe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr;
    logic tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
    int errors = 0;
    int check_count = 0;
    amsp_serial_unit amsp_serial_unit_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq),
        .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
        .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));
    amsp_station #(.BIT(4)) amsp_station_i (.pclk(pclk), .rxd(rxd),
        .txd(txd));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task summarize;
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            summarize();
        end
        q = prdata;
        qe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task rx(input logic [7:0] d, input logic mk, input logic stp);
        amsp_station_i.send(d, mk, stp);
        repeat (6) @(posedge pclk);
    endtask
    task t_reset;
        rd(amsp_pkg::ADDR_STAT);
        chk("status", q, 32'h3);
        rd(amsp_pkg::ADDR_BAUD);
        chk("baud", q, 32'h81);
        rd(8'h24);
        chk("slverr", qe, 1'b1);
        wr(amsp_pkg::ADDR_BAUD, 32'h3);
        wr(amsp_pkg::ADDR_CTRL, 32'ha1);
        repeat (3) @(negedge pclk);
        chk("txe irq", tx_empty_irq, 1'b1);
        chk("tx_end_flag irq", tx_end_irq, 1'b1);
        chk("rxf irq", rx_full_irq, 1'b0);
    endtask
    task t_tx;
        int n;
        wr(amsp_pkg::ADDR_CTRL, 32'h1ad);
        rd(amsp_pkg::ADDR_STAT);
        chk("txe before", q[0], 1'b1);
        wr(amsp_pkg::ADDR_TXH, 32'h5a);
        wr(amsp_pkg::ADDR_TXH, 32'h3c);
        wr(amsp_pkg::ADDR_TXH, 32'hc3);
        for (n = 0; n < 3000; n++) begin
            @(posedge pclk);
            if (amsp_station_i.got.size() >= 2) break;
        end
        if (n == 3000) begin
            errors++;
            summarize();
        end
        repeat (150) @(negedge pclk);
        chk("frames", amsp_station_i.got.size(), 2);
        chk("frame a", amsp_station_i.got[0], 10'h35a);
        chk("frame b", amsp_station_i.got[1], 10'h3c3);
        chk("tx_end_flag irq", tx_end_irq, 1'b1);
        chk("mark", txd, 1'b1);
    endtask
    task t_rx;
        wr(amsp_pkg::ADDR_ID, 32'h42);
        wr(amsp_pkg::ADDR_CTRL, 32'h4f);
        rx(8'h42, 1'b1, 1'b1);
        chk("rxf irq", rx_full_irq, 1'b1);
        rd(amsp_pkg::ADDR_RXD);
        chk("id", q, 32'h42);
        rx(8'h11, 1'b0, 1'b1);
        rd(amsp_pkg::ADDR_RXD);
        chk("data", q, 32'h11);
        rx(8'h07, 1'b1, 1'b1);
        rd(amsp_pkg::ADDR_RXD);
        rx(8'h99, 1'b0, 1'b1);
        rd(amsp_pkg::ADDR_STAT);
        chk("skip", q[7:2], 6'h30);
        chk("rxf irq", rx_full_irq, 1'b0);
        rd(amsp_pkg::ADDR_RXD);
        chk("kept", q, 32'h07);
    endtask
    task t_err;
        rx(8'h42, 1'b1, 1'b1);
        rx(8'h55, 1'b0, 1'b1);
        rx(8'h66, 1'b0, 1'b0);
        rd(amsp_pkg::ADDR_STAT);
        chk("errs", q[5:2], 4'h7);
        chk("err irq", rx_error_irq, 1'b1);
        rd(amsp_pkg::ADDR_RXD);
        chk("lost", q, 32'h42);
        wr(amsp_pkg::ADDR_STAT, 32'h0);
        rx(8'h77, 1'b0, 1'b0);
        rd(amsp_pkg::ADDR_STAT);
        chk("framing", q[5:2], 4'h5);
        rd(amsp_pkg::ADDR_RXD);
        chk("moved", q, 32'h77);
    endtask
    task t_irq;
        wr(amsp_pkg::ADDR_IRQ_EN, 32'hf);
        repeat (3) @(negedge pclk);
        chk("irq", irq, 1'b1);
        wr(amsp_pkg::ADDR_IRQ_CLR, 32'hf);
        rd(amsp_pkg::ADDR_IRQ_ST);
        chk("irq st", q, 32'h0);
        chk("irq", irq, 1'b0);
        wr(amsp_pkg::ADDR_IRQ_EN, 32'h0);
        rx(8'h12, 1'b0, 1'b1);
        rd(amsp_pkg::ADDR_IRQ_ST);
        chk("rxf st", q[2], 1'b1);
        chk("masked", irq, 1'b0);
        wr(amsp_pkg::ADDR_IRQ_EN, 32'h4);
        repeat (3) @(negedge pclk);
        chk("irq", irq, 1'b1);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        t_irq();
        summarize();
    end
endmodule // amsp_serial_unit_bench
